// >>> design/tep_edge_sync.sv
/*
 * Input pin synchroniser with agreement filter and edge pulses.
 * Assumes the pin is asynchronous to ref_clk; edges come out as
 * one-cycle registered pulses.
 */
`timescale 1ns/1ps

module tep_edge_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Raw pin
    input wire logic pin,
    // Filtered level and edges
    output logic level,
    output logic rise,
    output logic fall
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic primed;
        logic level;
        logic rise;
        logic fall;
    } tep_sync_t;

    tep_sync_t q;
    tep_sync_t d;

    // Shift chain; a change counts once stages two and three agree
    always_comb begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.rise = 1'b0;
        d.fall = 1'b0;
        if (q.s2 == q.s3) begin
            d.primed = 1'b1;
            d.level = q.s3;
            // First agreement only primes, no false edge
            if (q.primed && q.s3 != q.level) begin
                d.rise = q.s3;
                d.fall = ~q.s3;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.level;
    assign rise = q.rise;
    assign fall = q.fall;

endmodule // tep_edge_sync

// >>> design/tep_pkg.sv
/*
 * Constants shared by the timer channel: register offsets, field positions,
 * reset values, mode, polarity and prescaler encodings.
 * Assumes a 2-bit word address on the plain register port.
 */
package tep_pkg;

    // Register word offsets
    localparam logic [1:0] ADDR_COUNT = 2'h0;
    localparam logic [1:0] ADDR_MODE = 2'h1;
    localparam logic [1:0] ADDR_START = 2'h2;
    localparam logic [1:0] ADDR_ICTL = 2'h3;

    // Mode register field positions
    localparam int MODE_LSB = 0;
    localparam int POL_LSB = 2;
    localparam int OVF_BIT = 5;
    localparam int SRC_LSB = 6;

    // Start and interrupt control field positions
    localparam int START_BIT = 0;
    localparam int PRIO_LSB = 0;
    localparam int IREQ_BIT = 3;

    // Operating modes
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_MEAS = 2'h2;

    // Edge polarity codes
    localparam logic [1:0] POL_FALL = 2'h0;
    localparam logic [1:0] POL_RISE = 2'h1;
    localparam logic [1:0] POL_BOTH = 2'h2;

    // Prescaler masks for divide by 2, 16, 64, 512
    localparam logic [8:0] DIV2_MASK = 9'h001;
    localparam logic [8:0] DIV16_MASK = 9'h00F;
    localparam logic [8:0] DIV64_MASK = 9'h03F;
    localparam logic [8:0] DIV512_MASK = 9'h1FF;

    // Counter limits and reset values
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic OVF_RESET = 1'b1;

endpackage

// >>> design/tep_timer.sv
/*
 * One 16-bit timer channel: down-counting timer, event counter on the
 * channel input pin, and pulse period/width measurement.
 * Assumes ref_clk is the oscillator clock feeding the prescaler and
 * a plain register port with read data one cycle after the strobe.
 */
// Implementation choices: the address-and-strobe port and the register addresses.
// Function
// RL1 - Mode bits 00 select down-counting timer mode.
// RL2 - Timer mode: decrement per source pulse; underflow reloads and requests interrupt.
// RL3 - Loaded n gives one interrupt per n+1 source pulses.
// RL4 - Underflow in timer or event mode sets overflow flag with request.
// RL5 - Count write while stopped loads counter and reload together.
// RL6 - Count write while running goes to reload only, used at next underflow.
// RL7 - Timer and event modes read live counter; reload never readable.
// RL8 - Source feeds the counter only while the start flag is one.
// RL9 - Interrupt request stays set until accepted or cleared by software.
// RL10 - Mode 01 is event counting on input edges, source bits ignored.
// RL11 - Event polarity: 00 falling, 01 rising, 10 both edges.
// RL12 - Event mode decrements per edge; underflow reloads and requests interrupt.
// RL13 - Mode 10 measures: counter increments per source pulse while started.
// RL14 - Measurement edge copies counter to reload, then clears counter.
// RL15 - Measurement edges request interrupt except the first after start.
// RL16 - Measurement mode reads the captured value from reload register.
// RL17 - Measurement polarity: 00 fall-fall, 01 rise-rise, 10 every edge.
// RL18 - Input phases must last at least two source cycles.
// RL19 - Software decides whether a width result is high or low phase.
// RL20 - Software sets the shared pin to input before starting.
// RL21 - Software sets mode, then count, then start flag.
// RL22 - Measurement wrap from maximum to zero sets request and overflow.
// RL23 - Overflow flag is one after reset, cleared by mode register write.
// RL24 - Source bits 00..11 select oscillator divided by 2, 16, 64, 512.
// RL25 - Input pin synchronised before edge detection; source pulses are one-cycle enables.
`timescale 1ns/1ps

module tep_timer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Interrupt request and acceptance
    output logic irq_req,
    input wire logic irq_accept,
    // Channel input
    input wire logic channel_input_pin
);

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] rld;
        logic [1:0] mode;
        logic [1:0] pol;
        logic [1:0] src;
        logic ovf;
        logic start;
        logic [2:0] prio;
        logic ireq;
        logic first;
        logic [8:0] pre;
        logic tick;
        logic [15:0] rdata;
    } tep_state_t;

    tep_state_t q;
    tep_state_t d;

    logic in_level;
    logic in_rise;
    logic in_fall;
    logic [8:0] div_mask;
    logic edge_hit;
    logic src_pulse;
    logic cnt_wr;
    logic mode_wr;
    logic start_wr;
    logic ictl_wr;
    logic down_step;
    logic underflow;
    logic meas_edge;
    logic meas_wrap;
    logic ev_set;

    // Synchronised pin and edge pulses
    tep_edge_sync u_sync ( // [RL25]
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(channel_input_pin),
        .level(in_level),
        .rise(in_rise),
        .fall(in_fall)
    );

    // Prescaler tap for the selected count source
    always_comb begin
        case (q.src) // [RL24]
            2'h0: div_mask = tep_pkg::DIV2_MASK;
            2'h1: div_mask = tep_pkg::DIV16_MASK;
            2'h2: div_mask = tep_pkg::DIV64_MASK;
            2'h3: div_mask = tep_pkg::DIV512_MASK;
            default: div_mask = tep_pkg::DIV2_MASK;
        endcase
    end

    // Effective edge by polarity code
    always_comb begin
        case (q.pol)
            tep_pkg::POL_FALL: edge_hit = in_fall; // [RL11] [RL17]
            tep_pkg::POL_RISE: edge_hit = in_rise; // [RL11] [RL17]
            tep_pkg::POL_BOTH: edge_hit = in_rise | in_fall; // [RL11] [RL17]
            default: edge_hit = 1'b0;
        endcase
    end

    // Register strobes decoded from the port
    assign cnt_wr = reg_wr && (reg_addr == tep_pkg::ADDR_COUNT);
    assign mode_wr = reg_wr && (reg_addr == tep_pkg::ADDR_MODE);
    assign start_wr = reg_wr && (reg_addr == tep_pkg::ADDR_START);
    assign ictl_wr = reg_wr && (reg_addr == tep_pkg::ADDR_ICTL);

    // Source pulse gated by start; one cycle wide
    assign src_pulse = q.tick && q.start; // [RL8] [RL25]

    // Decrement step: internal source or input edge, by mode
    always_comb begin
        case (q.mode)
            tep_pkg::MODE_TIMER: down_step = src_pulse; // [RL1] [RL2]
            tep_pkg::MODE_EVENT: down_step = edge_hit && q.start; // [RL10] [RL12]
            default: down_step = 1'b0;
        endcase
    end

    // Underflow: counter at zero takes a step
    assign underflow = down_step && (q.cnt == tep_pkg::CNT_ZERO); // [RL3]

    // Measurement events
    assign meas_edge = (q.mode == tep_pkg::MODE_MEAS) && q.start && edge_hit; // [RL14]
    assign meas_wrap = (q.mode == tep_pkg::MODE_MEAS) && src_pulse && !edge_hit
        && (q.cnt == tep_pkg::CNT_MAX); // [RL22]

    // Any hardware request source this cycle
    assign ev_set = underflow || meas_wrap || (meas_edge && !q.first); // [RL15]

    // Next-state logic
    always_comb begin
        d = q;
        d.pre = q.pre + 9'h001;
        d.tick = ((q.pre & div_mask) == div_mask); // [RL24] [RL25]
        d.rdata = 16'h0000;

        // Counter behaviour per mode
        if (down_step) begin
            if (q.cnt == tep_pkg::CNT_ZERO) begin
                d.cnt = q.rld; // [RL2] [RL6] [RL12]
            end else begin
                d.cnt = q.cnt - 16'h0001; // [RL2] [RL12]
            end
        end
        if (q.mode == tep_pkg::MODE_MEAS) begin
            if (meas_edge) begin
                d.rld = q.cnt; // [RL14]
                d.cnt = tep_pkg::CNT_ZERO; // [RL14]
                d.first = 1'b0;
            end else if (src_pulse) begin
                d.cnt = q.cnt + 16'h0001; // [RL13] [RL22]
            end
        end

        // Count register write
        if (cnt_wr) begin
            d.rld = reg_wdata; // [RL5] [RL6]
            if (!q.start) begin
                d.cnt = reg_wdata; // [RL5]
            end
        end

        // Mode register write; overflow flag cleared unless set now
        if (mode_wr) begin
            d.mode = reg_wdata[tep_pkg::MODE_LSB +: 2];
            d.pol = reg_wdata[tep_pkg::POL_LSB +: 2];
            d.src = reg_wdata[tep_pkg::SRC_LSB +: 2];
            d.ovf = 1'b0; // [RL23]
        end
        if (underflow || meas_wrap) begin
            d.ovf = 1'b1; // [RL4] [RL22]
        end

        // Start flag; a fresh start arms first-edge suppression
        if (start_wr) begin
            d.start = reg_wdata[tep_pkg::START_BIT]; // [RL8]
            if (!q.start && reg_wdata[tep_pkg::START_BIT]) begin
                d.first = 1'b1; // [RL15]
            end
        end

        // Interrupt request bit: software write or acceptance, set wins
        if (ictl_wr) begin
            d.prio = reg_wdata[tep_pkg::PRIO_LSB +: 3];
            d.ireq = reg_wdata[tep_pkg::IREQ_BIT];
        end else if (irq_accept) begin
            d.ireq = 1'b0; // [RL9]
        end
        if (ev_set) begin
            d.ireq = 1'b1; // [RL2] [RL9] [RL12] [RL15]
        end

        // Read data, valid only in the cycle after the strobe
        if (reg_rd) begin
            case (reg_addr)
                tep_pkg::ADDR_COUNT: begin
                    if (q.mode == tep_pkg::MODE_MEAS) begin
                        d.rdata = q.rld; // [RL16]
                    end else begin
                        d.rdata = q.cnt; // [RL7]
                    end
                end
                tep_pkg::ADDR_MODE: begin
                    d.rdata[tep_pkg::MODE_LSB +: 2] = q.mode;
                    d.rdata[tep_pkg::POL_LSB +: 2] = q.pol;
                    d.rdata[tep_pkg::OVF_BIT] = q.ovf;
                    d.rdata[tep_pkg::SRC_LSB +: 2] = q.src;
                end
                tep_pkg::ADDR_START: begin
                    d.rdata[tep_pkg::START_BIT] = q.start;
                    d.rdata[1] = in_level;
                end
                tep_pkg::ADDR_ICTL: begin
                    d.rdata[tep_pkg::PRIO_LSB +: 3] = q.prio;
                    d.rdata[tep_pkg::IREQ_BIT] = q.ireq;
                end
                default: d.rdata = 16'h0000;
            endcase
        end
    end

    // State register; overflow flag comes out of reset set
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.ovf <= tep_pkg::OVF_RESET; // [RL23]
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = q.rdata;
    assign irq_req = q.ireq;

endmodule // tep_timer

// >>> tb/tep_pulse_src.sv
/* Pulse source for the channel input pin.
   Assumes the bench sets phase lengths while disabled. */
`timescale 1ns/1ps

module tep_pulse_src (
    // Control
    input wire logic ref_clk,
    input wire logic en,
    input wire logic [7:0] lo_len,
    input wire logic [7:0] hi_len,
    // Pin
    output logic pin
);
    logic [7:0] cnt_q = 8'h01;
    initial pin = 1'b0;
    // Low while off, then phases of set length; pin only drives into the block
    always @(posedge ref_clk) begin
        if (!en) begin
            cnt_q <= 8'h01;
            pin <= 1'b0;
        end else if (cnt_q >= (pin ? hi_len : lo_len)) begin
            cnt_q <= 8'h01;
            pin <= ~pin;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // tep_pulse_src

// >>> tb/tep_timer_chk.sv
/* Checker on the timer channel ports.
   Assumes binding to tep_timer. */
`timescale 1ns/1ps

module tep_timer_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Interrupt and pin
    input wire logic irq_req,
    input wire logic irq_accept,
    input wire logic channel_input_pin
);
    logic run_q;
    logic ictl_wr;
    assign ictl_wr = reg_wr && reg_addr == tep_pkg::ADDR_ICTL;
    // Mirror of the start flag
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
        end else if (reg_wr && reg_addr == tep_pkg::ADDR_START) begin
            run_q <= reg_wdata[tep_pkg::START_BIT];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero");
    a_irq_hold: assert property (irq_req && !irq_accept && !ictl_wr |=> irq_req)
        else $error("request dropped");
    a_irq_swset: assert property (ictl_wr && reg_wdata[tep_pkg::IREQ_BIT] |=> irq_req)
        else $error("request not set");
    a_accept_clear: assert property (irq_accept && !run_q && !reg_wr |=> !irq_req)
        else $error("accept did not clear");
    a_stop_quiet: assert property (!run_q && !ictl_wr |=> !$rose(irq_req))
        else $error("request while stopped");
    a_ictl_read: assert property (reg_rd && reg_addr == tep_pkg::ADDR_ICTL |=>
        reg_rdata[15:3] == {12'h000, $past(irq_req)}) else $error("control read wrong");
    a_start_read: assert property (reg_rd && reg_addr == tep_pkg::ADDR_START |=>
        reg_rdata[0] == $past(run_q) && reg_rdata[15:2] == 14'h0000) else $error("start read wrong");
    a_ovf_clear: assert property (reg_wr && reg_addr == tep_pkg::ADDR_MODE && !run_q ##1 !reg_wr
        ##1 reg_rd && reg_addr == tep_pkg::ADDR_MODE |=> !reg_rdata[tep_pkg::OVF_BIT])
        else $error("overflow not cleared");
endmodule // tep_timer_chk

bind tep_timer tep_timer_chk u_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_req(irq_req), .irq_accept(irq_accept), .channel_input_pin(channel_input_pin));

// >>> tb/testbench.sv
/* Self-checking bench: timer, event and measurement scenarios.
   Assumes the pulse source model and the bound checker. */
`timescale 1ns/1ps

module testbench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic irq_req;
    logic irq_accept = 1'b0;
    logic pin;
    logic src_en = 1'b0;
    logic [7:0] lo_len = 8'h08;
    logic [7:0] hi_len = 8'h09;
    logic [15:0] v;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    int c;
    int dv[4] = '{2, 16, 64, 512};
    int ev[3] = '{31, 31, 14};
    int mi[3] = '{14, 14, 6};
    int mc[3] = '{8, 8, 4};

    tep_timer DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req),
        .irq_accept(irq_accept), .channel_input_pin(pin));
    tep_pulse_src u_src (.ref_clk(ref_clk), .en(src_en), .lo_len(lo_len), .hi_len(hi_len), .pin(pin));

    // Clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        v = reg_rdata;
    endtask

    // Clear, sync to a request, clear, count edges to the next one
    task automatic period();
        repeat (2) begin
            wr(tep_pkg::ADDR_ICTL, 16'h0000);
            @(posedge ref_clk);
            c = 0;
            while (irq_req !== 1'b1) begin
                @(posedge ref_clk);
                c++;
            end
        end
    endtask

    // Main sequence: mode, count, then start in the timer, event and wrap scenarios
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd(tep_pkg::ADDR_MODE);
        chk(v, 16'h0020);
        wr(tep_pkg::ADDR_MODE, 16'h0000);
        rd(tep_pkg::ADDR_MODE);
        chk(v, 16'h0000);
        wr(tep_pkg::ADDR_COUNT, 16'hABCD);
        rd(tep_pkg::ADDR_COUNT);
        chk(v, 16'hABCD);
        // Timer mode over all prescaler codes, n = 1
        for (int s = 0; s < 4; s++) begin
            wr(tep_pkg::ADDR_MODE, 16'(s << 6));
            wr(tep_pkg::ADDR_COUNT, 16'h0001);
            wr(tep_pkg::ADDR_START, 16'h0001);
            period();
            chk(16'(c), 16'(2 * dv[s] - 3));
            wr(tep_pkg::ADDR_START, 16'h0000);
        end
        // Running count write takes effect at the next underflow; divide by 2
        wr(tep_pkg::ADDR_MODE, 16'h0000);
        wr(tep_pkg::ADDR_START, 16'h0001);
        rd(tep_pkg::ADDR_START);
        chk(v, 16'h0001);
        wr(tep_pkg::ADDR_COUNT, 16'h0004);
        period();
        chk(16'(c), 16'h0007);
        rd(tep_pkg::ADDR_MODE);
        chk(v, 16'h0020);
        wr(tep_pkg::ADDR_START, 16'h0000);
        irq_accept <= 1'b1;
        @(posedge ref_clk);
        irq_accept <= 1'b0;
        @(posedge ref_clk);
        chk({15'h0000, irq_req}, 16'h0000);
        wr(tep_pkg::ADDR_ICTL, 16'h0008);
        repeat (20) @(posedge ref_clk);
        rd(tep_pkg::ADDR_ICTL);
        chk(v & 16'h0008, 16'h0008);
        // Event counting, source bits set but ignored, n = 1
        for (int p = 0; p < 3; p++) begin
            wr(tep_pkg::ADDR_MODE, 16'h00C1 | 16'(p << 2));
            wr(tep_pkg::ADDR_COUNT, 16'h0001);
            wr(tep_pkg::ADDR_START, 16'h0001);
            src_en <= 1'b1;
            period();
            chk(16'(c), 16'(ev[p]));
            wr(tep_pkg::ADDR_START, 16'h0000);
            src_en <= 1'b0;
        end
        // Measurement: period, then width with equal phases so both widths match
        for (int p = 0; p < 3; p++) begin
            lo_len <= (p == 2) ? 8'h09 : 8'h08;
            wr(tep_pkg::ADDR_ICTL, 16'h0000);
            wr(tep_pkg::ADDR_MODE, 16'h0002 | 16'(p << 2));
            wr(tep_pkg::ADDR_START, 16'h0001);
            src_en <= 1'b1;
            repeat ((p == 0) ? 24 : 16) @(posedge ref_clk);
            chk({15'h0000, irq_req}, 16'h0000);
            period();
            chk(16'(c), 16'(mi[p]));
            rd(tep_pkg::ADDR_COUNT);
            chk(v, 16'(mc[p]));
            wr(tep_pkg::ADDR_START, 16'h0000);
            src_en <= 1'b0;
        end
        // Measurement wrap from the maximum count, pin held idle
        wr(tep_pkg::ADDR_MODE, 16'h0002);
        wr(tep_pkg::ADDR_ICTL, 16'h0000);
        wr(tep_pkg::ADDR_COUNT, 16'hFFFF);
        rd(tep_pkg::ADDR_MODE);
        chk(v, 16'h0002);
        wr(tep_pkg::ADDR_START, 16'h0001);
        repeat (8) @(posedge ref_clk);
        rd(tep_pkg::ADDR_MODE);
        chk(v, 16'h0022);
        rd(tep_pkg::ADDR_ICTL);
        chk(v, 16'h0008);
        give_verdict();
    end
endmodule // testbench
